//--- src/sc_serial_ctrl.sv
// Smart card serial channel: control, transmit holding and status registers
// Assumes receive path reports events on the same clock; one clock mclk
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`include "sc_serial_regs.svh"
module sc_serial_ctrl (
    input wire logic mclk,
    input wire logic rst,
    input sc_serial_pkg::bus_req_s bus,
    output logic [7:0] rdata,
    input sc_serial_pkg::rx_event_s rx_ev,
    input sc_serial_pkg::dtc_req_s transfer_controller,
    output logic tx_empty_irq,
    output logic irq,
    output logic sd_out,
    output logic sd_oe
);
    import sc_serial_pkg::*;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0] control_reg, control_next;
    logic [7:0] holding_reg, holding_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] armed_reg, armed_next;
    logic [7:0] half_etu_reg, half_etu_next;
    logic guard_mode_reg, guard_mode_next;
    logic [3:0] irq_st_reg, irq_st_next;
    logic [3:0] irq_mask_reg, irq_mask_next;
    logic [7:0] rdata_reg, rdata_next;

    // Transmitter state
    tx_state_e state_reg, state_next;
    logic [9:0] shift_reg, shift_next;
    logic [4:0] half_cnt_reg, half_cnt_next;
    logic sd_out_reg, sd_out_next;

    logic te, tx_interrupt_enable, tick, load, guard_done, dtc_take;
    logic st_wr, st_rd;
    logic [7:0] clr_sw;
    logic [4:0] guard_len;

    // Address decode, shared by read and write paths
    function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
        return a == base;
    endfunction : hit

    assign te = control_reg[`SC_TX_EN];
    assign tx_interrupt_enable = control_reg[`SC_TX_INT_EN];
    assign st_wr = bus.wr && hit(bus.addr, `ADDR_SERIAL_STATUS);
    assign st_rd = bus.rd && hit(bus.addr, `ADDR_SERIAL_STATUS);
    assign guard_len = guard_mode_reg ? `GUARD_HALF_GM1 : `GUARD_HALF_GM0;

    // ----------------------------------------
    // Interrupt outputs
    // ----------------------------------------
    // Gated request
    assign tx_empty_irq = tx_interrupt_enable && status_reg[`ST_TX_BUFFER_EMPTY_FLAG];
    assign irq = |(irq_st_reg & irq_mask_reg);
    // Controller is only honoured as a response to a live request
    assign dtc_take = transfer_controller.wr && tx_empty_irq;
    assign rdata = rdata_reg;
    assign sd_out = sd_out_reg;
    assign sd_oe = (state_reg == TX_DATA);

    etu_tick u_etu (
        .mclk(mclk),
        .rst(rst),
        .restart(load),
        .half_etu(half_etu_reg),
        .tick(tick)
    );

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    // Start, eight data LSB first, even parity; each bit is two half ticks
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        half_cnt_next = half_cnt_reg;
        sd_out_next = 1'b1;
        load = 1'b0;
        guard_done = 1'b0;
        unique case (state_reg)
            TX_IDLE: begin
                if (te && !status_reg[`ST_TX_BUFFER_EMPTY_FLAG]) begin
                    load = 1'b1;
                    shift_next = {^holding_reg, holding_reg, 1'b0};
                    sd_out_next = 1'b0; // Start bit leaves with the load, full length
                    half_cnt_next = 5'd0;
                    state_next = TX_DATA;
                end
            end
            TX_DATA: begin
                sd_out_next = shift_reg[0];
                if (tick) begin
                    half_cnt_next = half_cnt_reg + 5'd1;
                    if (half_cnt_reg[0]) begin
                        shift_next = {1'b1, shift_reg[9:1]};
                        sd_out_next = shift_reg[1];
                    end
                    if (half_cnt_reg == `FRAME_HALF_ETU - 5'd1) begin
                        half_cnt_next = 5'd0;
                        sd_out_next = 1'b1;
                        state_next = TX_GUARD;
                    end
                end
            end
            TX_GUARD: begin
                if (tick) begin
                    half_cnt_next = half_cnt_reg + 5'd1;
                    if (half_cnt_reg == guard_len - 5'd1) begin
                        guard_done = 1'b1;
                        state_next = TX_IDLE;
                    end
                end
            end
        endcase
        if (!te) begin
            state_next = TX_IDLE;
            sd_out_next = 1'b1;
            load = 1'b0;
            guard_done = 1'b0;
        end
    end

    // Register only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= TX_IDLE;
            shift_reg <= 10'h3ff;
            half_cnt_reg <= 5'd0;
            sd_out_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            half_cnt_reg <= half_cnt_next;
            sd_out_reg <= sd_out_next;
        end
    end

    // ----------------------------------------
    // Registers and flags
    // ----------------------------------------
    // Clears are applied first so that a same-cycle set always wins
    always_comb begin
        control_next = control_reg;
        holding_next = holding_reg;
        status_next = status_reg;
        armed_next = armed_reg;
        half_etu_next = half_etu_reg;
        guard_mode_next = guard_mode_reg;
        irq_st_next = irq_st_reg;
        irq_mask_next = irq_mask_reg;
        rdata_next = 8'h00;
        clr_sw = 8'h00;
        // Zero clears only an armed flag
        if (st_wr) begin
            clr_sw = ~bus.wdata & armed_reg & `CLEARABLE_MASK;
            armed_next = 8'h00;
            status_next[`ST_TX_MULTIPROC_BIT] = bus.wdata[`ST_TX_MULTIPROC_BIT];
        end
        if (st_rd) begin
            armed_next = armed_reg | (status_reg & `CLEARABLE_MASK);
        end
        status_next = status_next & ~clr_sw;
        // Software empty clear ends transmit end too
        if (clr_sw[`ST_TX_BUFFER_EMPTY_FLAG]) begin
            status_next[`ST_TX_END_FLAG] = 1'b0;
        end
        if (bus.wr && hit(bus.addr, `ADDR_SERIAL_CONTROL)) begin
            control_next = bus.wdata;
        end
        if (bus.wr && hit(bus.addr, `ADDR_TRANSMIT_HOLDING)) begin
            holding_next = bus.wdata;
        end
        if (bus.wr && hit(bus.addr, `ADDR_HALF_ETU)) begin
            half_etu_next = bus.wdata;
        end
        if (bus.wr && hit(bus.addr, `ADDR_GUARD_CFG)) begin
            guard_mode_next = bus.wdata[0];
        end
        if (bus.wr && hit(bus.addr, `ADDR_IRQ_MASK)) begin
            irq_mask_next = bus.wdata[3:0];
        end
        if (bus.wr && hit(bus.addr, `ADDR_IRQ_STATUS)) begin
            irq_st_next = irq_st_reg & ~bus.wdata[3:0];
        end
        if (dtc_take) begin
            holding_next = transfer_controller.data;
            status_next[`ST_TX_END_FLAG] = 1'b0;
            if (!transfer_controller.disable_after_transfer && !transfer_controller.count_zero) begin
                status_next[`ST_TX_BUFFER_EMPTY_FLAG] = 1'b0;
            end
        end
        if (!te || load) begin
            status_next[`ST_TX_BUFFER_EMPTY_FLAG] = 1'b1;
        end
        // End set after guard, if normal transmission
        if (!te || (guard_done && status_next[`ST_TX_BUFFER_EMPTY_FLAG] && !status_reg[`ST_ERS])) begin
            status_next[`ST_TX_END_FLAG] = 1'b1;
        end
        if (rx_ev.char_done) begin
            status_next[`ST_RX_BUFFER_FULL_FLAG] = 1'b1;
            status_next[`ST_MPB] = rx_ev.rx_multiproc_bit;
        end
        if (rx_ev.overrun) status_next[`ST_OVERRUN_FLAG] = 1'b1;
        if (rx_ev.err_sig) status_next[`ST_ERS] = 1'b1;
        if (rx_ev.parity_err) status_next[`ST_PER] = 1'b1;
        // Sticky events; set wins over write-one clear
        if (load) irq_st_next[`IRQ_TX_EMPTY] = 1'b1;
        if (guard_done) irq_st_next[`IRQ_TX_END] = 1'b1;
        if (rx_ev.parity_err) irq_st_next[`IRQ_PARITY] = 1'b1;
        if (rx_ev.err_sig) irq_st_next[`IRQ_ERR_SIG] = 1'b1;
        if (bus.rd) begin
            unique case (bus.addr)
                `ADDR_SERIAL_CONTROL: rdata_next = control_reg;
                `ADDR_TRANSMIT_HOLDING: rdata_next = holding_reg;
                `ADDR_SERIAL_STATUS: rdata_next = status_reg;
                `ADDR_HALF_ETU: rdata_next = half_etu_reg;
                `ADDR_GUARD_CFG: rdata_next = {7'h00, guard_mode_reg};
                `ADDR_IRQ_STATUS: rdata_next = {4'h0, irq_st_reg};
                `ADDR_IRQ_MASK: rdata_next = {4'h0, irq_mask_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            control_reg <= `CONTROL_RESET;
            holding_reg <= `HOLDING_RESET;
            status_reg <= `STATUS_RESET;
            armed_reg <= 8'h00;
            half_etu_reg <= `HALF_ETU_RESET;
            guard_mode_reg <= 1'b0;
            irq_st_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
            rdata_reg <= 8'h00;
        end else begin
            control_reg <= control_next;
            holding_reg <= holding_next;
            status_reg <= status_next;
            armed_reg <= armed_next;
            half_etu_reg <= half_etu_next;
            guard_mode_reg <= guard_mode_next;
            irq_st_reg <= irq_st_next;
            irq_mask_reg <= irq_mask_next;
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_txi_gated: assert property (@(posedge mclk) disable iff (rst)
        transfer_controller.wr && !tx_empty_irq && !bus.wr |=> holding_reg == $past(holding_reg))
        else $error("controller write taken without empty request");

    a_holding_write: assert property (@(posedge mclk) disable iff (rst)
        bus.wr && bus.addr == `ADDR_TRANSMIT_HOLDING && !dtc_take
        |=> holding_reg == $past(bus.wdata))
        else $error("holding register not written");

    a_tx_buffer_empty_flag_te_off: assert property (@(posedge mclk) disable iff (rst)
        !te |=> status_reg[`ST_TX_BUFFER_EMPTY_FLAG] && status_reg[`ST_TX_END_FLAG])
        else $error("empty or end flag low while disabled");

    a_write_one_noop: assert property (@(posedge mclk) disable iff (rst)
        st_wr && bus.wdata[`ST_PER] && status_reg[`ST_PER] |=> status_reg[`ST_PER])
        else $error("writing one cleared a flag");

    a_dtc_blocked: assert property (@(posedge mclk) disable iff (rst)
        dtc_take && (transfer_controller.disable_after_transfer || transfer_controller.count_zero) |=> status_reg[`ST_TX_BUFFER_EMPTY_FLAG])
        else $error("controller cleared empty flag while blocked");

    a_dtc_tx_end_flag_clear: assert property (@(posedge mclk) disable iff (rst)
        dtc_take && te && state_reg == TX_IDLE |=> !status_reg[`ST_TX_END_FLAG])
        else $error("transmit end not cleared by controller write");

    a_guard_gm0: assert property (@(posedge mclk) disable iff (rst)
        guard_done && !guard_mode_reg |-> half_cnt_reg == 5'd4 && tick)
        else $error("guard not 2.5 etu");

    a_guard_gm1: assert property (@(posedge mclk) disable iff (rst)
        guard_done && guard_mode_reg |-> half_cnt_reg == 5'd1 && tick)
        else $error("guard not 1.0 etu");

    a_parity_clear: assert property (@(posedge mclk) disable iff (rst)
        st_wr && !bus.wdata[`ST_PER] && !armed_reg[`ST_PER] && status_reg[`ST_PER]
        |=> status_reg[`ST_PER])
        else $error("parity flag cleared without prior read");

    a_mpb_follow: assert property (@(posedge mclk) disable iff (rst)
        rx_ev.char_done |=> status_reg[`ST_MPB] == $past(rx_ev.rx_multiproc_bit))
        else $error("multiprocessor flag not updated");

    a_idle_when_off: assert property (@(posedge mclk) disable iff (rst)
        !te |=> !sd_oe && sd_out)
        else $error("line driven while transmitter disabled");

endmodule : sc_serial_ctrl

//--- include/sc_serial_regs.svh
// Register addresses, field positions, reset values and frame timing
// Assumes an 8-bit register port with 16-bit addresses
`ifndef SC_SERIAL_REGS_SVH
`define SC_SERIAL_REGS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_SERIAL_CONTROL 16'hff8a
`define ADDR_TRANSMIT_HOLDING 16'hff8b
`define ADDR_SERIAL_STATUS 16'hff8c
`define ADDR_HALF_ETU 16'hff80
`define ADDR_GUARD_CFG 16'hff81
`define ADDR_IRQ_STATUS 16'hff82
`define ADDR_IRQ_MASK 16'hff83

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SC_TX_INT_EN 7
`define SC_RX_INT_EN 6
`define SC_TX_EN 5
`define ST_TX_BUFFER_EMPTY_FLAG 7
`define ST_RX_BUFFER_FULL_FLAG 6
`define ST_OVERRUN_FLAG 5
`define ST_ERS 4
`define ST_PER 3
`define ST_TX_END_FLAG 2
`define ST_MPB 1
`define ST_TX_MULTIPROC_BIT 0
`define IRQ_TX_EMPTY 0
`define IRQ_TX_END 1
`define IRQ_PARITY 2
`define IRQ_ERR_SIG 3

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define CONTROL_RESET 8'h00
`define STATUS_RESET 8'h84
`define HOLDING_RESET 8'hff
`define HALF_ETU_RESET 8'hba
`define CLEARABLE_MASK 8'hf8
`define FRAME_HALF_ETU 5'd20
`define GUARD_HALF_GM0 5'd5
`define GUARD_HALF_GM1 5'd2

`endif

//--- include/sc_serial_pkg.sv
// Types shared by the smart card serial control and status block
// Assumes the register header is compiled alongside
package sc_serial_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DATA = 2'b01,
        TX_GUARD = 2'b11
    } tx_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic char_done;
        logic rx_multiproc_bit;
        logic parity_err;
        logic overrun;
        logic err_sig;
    } rx_event_s;

    typedef struct packed {
        logic wr;
        logic [7:0] data;
        logic disable_after_transfer;
        logic count_zero;
    } dtc_req_s;

endpackage : sc_serial_pkg

//--- src/etu_tick.sv
// Half elementary time unit tick generator
// Assumes one clock; restart realigns the tick to a frame start
`timescale 1ns/1ns
module etu_tick (
    input wire logic mclk,
    input wire logic rst,
    input wire logic restart,
    input wire logic [7:0] half_etu,
    output logic tick
);

    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;

    // ----------------------------------------
    // Down counter
    // ----------------------------------------
    // Reload on zero, so the period is half_etu plus one cycles
    always_comb begin
        tick = (cnt_reg == 8'h00) && !restart;
        if (restart || cnt_reg == 8'h00) begin
            cnt_next = half_etu;
        end else begin
            cnt_next = cnt_reg - 8'h01;
        end
    end

    // Register only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule : etu_tick

//--- dv/sc_card_model.sv
// Card side model: samples each frame on the serial line mid-bit
// Assumes half_etu is programmed to one, so a bit lasts four mclk cycles
`timescale 1ns/1ns
module sc_card_model #(
    parameter int BIT_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sd_out,
    input wire logic sd_oe,
    output logic [7:0] rx_byte,
    output logic parity_ok,
    output logic [7:0] n_frames
);
    logic [9:0] shift;
    logic oe_d;
    int cnt;

    // ----------------------------------------
    // Frame capture
    // ----------------------------------------
    // One sample per etu, only while driven
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            shift <= 10'h3ff;
            oe_d <= 1'b0;
            cnt <= -1;
            rx_byte <= 8'h00;
            parity_ok <= 1'b0;
            n_frames <= 8'h00;
        end else begin
            oe_d <= sd_oe;
            if (sd_oe && !oe_d) begin
                cnt <= 0;
            end else if (cnt >= 0) begin
                cnt <= cnt + 1;
            end
            // Second cycle of each bit, well clear of the next bit edge
            if (sd_oe && cnt >= 0 && cnt % BIT_CYCLES == 0 && cnt < 10 * BIT_CYCLES) begin
                shift <= {sd_out, shift[9:1]};
            end
            // A frame cut short by an abort is not counted
            if (!sd_oe && oe_d) begin
                cnt <= -1;
                if (cnt >= 9 * BIT_CYCLES) begin
                    rx_byte <= shift[8:1];
                    parity_ok <= (^shift[9:1] == 1'b0) && !shift[0];
                    n_frames <= n_frames + 8'h01;
                end
            end
        end
    end
endmodule : sc_card_model

//--- dv/smart_card_serial_ctrl_status_tb_top.sv
// Self-checking bench for the smart card control and status block
// Assumes the card model and the register header are compiled alongside
`timescale 1ns/1ns
`include "sc_serial_regs.svh"
module smart_card_serial_ctrl_status_tb_top;
    import sc_serial_pkg::*;
    logic mclk;
    logic rst;
    bus_req_s bus;
    rx_event_s rx_ev;
    dtc_req_s transfer_controller;
    logic [7:0] rdata;
    logic tx_empty_irq;
    logic irq;
    logic sd_out;
    logic sd_oe;
    logic [7:0] rx_byte;
    logic [7:0] n_frames;
    logic parity_ok;
    logic [7:0] rd_val;
    int n_fail;
    int total_checks;

    sc_serial_ctrl uut (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .rx_ev(rx_ev),
        .transfer_controller(transfer_controller), .tx_empty_irq(tx_empty_irq), .irq(irq), .sd_out(sd_out), .sd_oe(sd_oe));
    sc_card_model card (.mclk(mclk), .rst(rst), .sd_out(sd_out), .sd_oe(sd_oe),
        .rx_byte(rx_byte), .parity_ok(parity_ok), .n_frames(n_frames));

    // ----------------------------------------
    // Clock and shared tasks
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // Settle time after the strobe edge so flags are read after they land
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        bus.wr <= 1'b0;
        #1;
    endtask : reg_wr

    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    task automatic rx_pulse(input rx_event_s e);
        @(posedge mclk);
        rx_ev <= e;
        @(posedge mclk);
        rx_ev <= '0;
    endtask : rx_pulse

    task automatic dtc_wr(input logic [7:0] d, input logic dis, input logic cz);
        @(posedge mclk);
        transfer_controller <= '{wr: 1'b1, data: d, disable_after_transfer: dis, count_zero: cz};
        @(posedge mclk);
        transfer_controller.wr <= 1'b0;
        #1;
    endtask : dtc_wr

    task automatic wait_oe(input logic level);
        for (int i = 0; i < 300; i++) begin
            @(posedge mclk);
            #1;
            if (sd_oe === level) return;
        end
        n_fail++;
        $display("unexpected at %0t: seen %h expected %h", $time, sd_oe, level);
        print_verdict();
    endtask : wait_oe

    // Counts cycles from end of frame until the end flag reads back set
    task automatic wait_end(output int cyc);
        cyc = 0;
        do begin
            reg_rd(`ADDR_SERIAL_STATUS, rd_val);
            cyc += 2;
        end while (rd_val[`ST_TX_END_FLAG] !== 1'b1 && cyc < 100);
        if (rd_val[`ST_TX_END_FLAG] !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, rd_val, 8'h04);
            print_verdict();
        end
    endtask : wait_end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        chk(rd_val, 8'h84);
        reg_rd(`ADDR_TRANSMIT_HOLDING, rd_val);
        chk(rd_val, 8'hff);
        reg_rd(`ADDR_SERIAL_CONTROL, rd_val);
        chk(rd_val, 8'h00);
        reg_rd(16'hff90, rd_val);
        chk(rd_val, 8'h00);
        chk({7'h0, tx_empty_irq}, 8'h00);
        chk({7'h0, sd_oe}, 8'h00);
        reg_wr(`ADDR_TRANSMIT_HOLDING, 8'h5a);
        reg_rd(`ADDR_TRANSMIT_HOLDING, rd_val);
        chk(rd_val, 8'h5a);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_flags();
        // Transmitter off: empty and end cannot be cleared
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        reg_wr(`ADDR_SERIAL_STATUS, 8'h00);
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        chk(rd_val, 8'h84);
        rx_pulse('{char_done: 1'b1, rx_multiproc_bit: 1'b1, parity_err: 1'b1, overrun: 1'b0, err_sig: 1'b0});
        reg_wr(`ADDR_IRQ_MASK, 8'h04);
        chk({7'h0, irq}, 8'h01);
        reg_wr(`ADDR_IRQ_MASK, 8'h00);
        chk({7'h0, irq}, 8'h00);
        // Receive full stays set: every write below keeps a one in bit 6
        reg_wr(`ADDR_SERIAL_STATUS, 8'hff);
        reg_wr(`ADDR_SERIAL_STATUS, 8'hf5);
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        chk(rd_val, 8'hcf);
        reg_wr(`ADDR_SERIAL_STATUS, 8'hf5);
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        chk(rd_val, 8'hc7);
        rx_pulse('{char_done: 1'b1, rx_multiproc_bit: 1'b0, parity_err: 1'b0, overrun: 1'b0, err_sig: 1'b0});
        reg_wr(`ADDR_SERIAL_STATUS, 8'hfc);
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        chk(rd_val, 8'hc4);
        reg_wr(`ADDR_IRQ_STATUS, 8'h04);
        reg_wr(`ADDR_IRQ_MASK, 8'h04);
        chk({7'h0, irq}, 8'h00);
        $display("test_flags done");
    endtask : test_flags

    task automatic test_tx(input logic [7:0] d, input logic gm, input logic [7:0] nf);
        int cyc;
        reg_wr(`ADDR_HALF_ETU, 8'h01);
        reg_wr(`ADDR_GUARD_CFG, {7'h0, gm});
        reg_wr(`ADDR_SERIAL_CONTROL, 8'h20);
        reg_wr(`ADDR_IRQ_MASK, 8'h03);
        reg_wr(`ADDR_TRANSMIT_HOLDING, d);
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        reg_wr(`ADDR_SERIAL_STATUS, 8'h7e);
        wait_oe(1'b1);
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        chk(rd_val & 8'h84, 8'h80);
        wait_oe(1'b0);
        wait_end(cyc);
        chk(rx_byte, d);
        chk({7'h0, parity_ok}, 8'h01);
        chk(n_frames, nf);
        // Status polled every two cycles: 1.0 etu is seen on read 3, 2.5 etu on read 6
        if (gm) chk({7'h0, cyc == 6}, 8'h01);
        else chk({7'h0, cyc == 12}, 8'h01);
        chk({7'h0, irq}, 8'h01);
        reg_wr(`ADDR_IRQ_STATUS, 8'h03);
        chk({7'h0, irq}, 8'h00);
        $display("test_tx done, guard mode %0d", gm);
    endtask : test_tx

    task automatic test_dtc();
        int cyc;
        reg_wr(`ADDR_SERIAL_CONTROL, 8'ha0);
        chk({7'h0, tx_empty_irq}, 8'h01);
        reg_wr(`ADDR_SERIAL_CONTROL, 8'h20);
        chk({7'h0, tx_empty_irq}, 8'h00);
        // No request while the interrupt is off, so the controller is ignored
        dtc_wr(8'h99, 1'b0, 1'b0);
        reg_rd(`ADDR_TRANSMIT_HOLDING, rd_val);
        chk(rd_val, 8'h3e);
        reg_wr(`ADDR_SERIAL_CONTROL, 8'ha0);
        dtc_wr(8'h3c, 1'b1, 1'b0);
        reg_rd(`ADDR_TRANSMIT_HOLDING, rd_val);
        chk(rd_val, 8'h3c);
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        chk(rd_val & 8'h84, 8'h80);
        dtc_wr(8'h66, 1'b0, 1'b1);
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        chk({7'h0, rd_val[`ST_TX_BUFFER_EMPTY_FLAG]}, 8'h01);
        dtc_wr(8'hc3, 1'b0, 1'b0);
        wait_oe(1'b1);
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        chk({7'h0, rd_val[`ST_TX_END_FLAG]}, 8'h00);
        wait_oe(1'b0);
        wait_end(cyc);
        chk(rx_byte, 8'hc3);
        chk({7'h0, cyc == 6}, 8'h01);
        $display("test_dtc done");
    endtask : test_dtc

    task automatic test_abort();
        reg_wr(`ADDR_SERIAL_CONTROL, 8'h20);
        reg_wr(`ADDR_TRANSMIT_HOLDING, 8'h0f);
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        reg_wr(`ADDR_SERIAL_STATUS, 8'h7e);
        wait_oe(1'b1);
        repeat (8) @(posedge mclk);
        reg_wr(`ADDR_SERIAL_CONTROL, 8'h00);
        repeat (2) @(posedge mclk);
        #1 chk({7'h0, sd_oe}, 8'h00);
        chk({7'h0, sd_out}, 8'h01);
        reg_rd(`ADDR_SERIAL_STATUS, rd_val);
        chk(rd_val & 8'h84, 8'h84);
        chk(n_frames, 8'h03);
        $display("test_abort done");
    endtask : test_abort

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        bus = '0;
        rx_ev = '0;
        transfer_controller = '0;
        n_fail = 0;
        total_checks = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        test_reset();
        test_flags();
        test_tx(8'ha5, 1'b0, 8'h01);
        test_tx(8'h3e, 1'b1, 8'h02);
        test_dtc();
        test_abort();
        print_verdict();
    end
endmodule : smart_card_serial_ctrl_status_tb_top
